/* File: hdl/rsu_pkg.sv */
// Purpose: Shared constants and carrier types for the ring stop usage
//          event select block.
// Assumes: One core clock; ring indications arrive on that clock.
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package rsu_pkg;

    // ==========================================================
    // Event codes and unit-mask layout
    localparam logic [7:0] EV_REQ_USE = 8'h1b;
    localparam logic [7:0] EV_ACK_USE = 8'h1c;
    localparam logic [7:0] EV_DATA_USE = 8'h1d;
    localparam logic [7:0] EV_INV_USE = 8'h1e;
    localparam logic [7:0] EV_BOUNCE = 8'h05;
    localparam logic [7:0] UMASK_UP = 8'h33;
    localparam logic [7:0] UMASK_DOWN = 8'hcc;
    localparam int UM_V1_BASE = 4;
    localparam int BNC_UMASK_LSB = 1;

    // ==========================================================
    // Counter placement limits
    localparam int NUM_CTRS = 4;
    localparam int USAGE_CTR_LO = 2;
    localparam int USAGE_CTR_HI = 3;
    localparam int BOUNCE_CTR_LO = 0;
    localparam int BOUNCE_CTR_HI = 1;

    // ==========================================================
    // Register map and field positions
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTL0 = 8'h00;
    localparam logic [7:0] ADDR_CTR0 = 8'h10;
    localparam logic [7:0] ADDR_CFG = 8'h20;
    localparam logic [7:0] ADDR_STAT = 8'h24;
    localparam int CTL_EVENT_LSB = 0;
    localparam int CTL_UMASK_LSB = 8;
    localparam int CTL_ENABLE_BIT = 22;
    localparam int SLICE_W = 6;
    localparam int CFG_ID_LSB = 0;
    localparam int CFG_COUNT_LSB = 8;
    localparam int STAT_SIDE_BIT = 4;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [31:0] CTR_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST = 32'h0000_0200;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Carrier types
    typedef enum logic [2:0] {
        REG_CTL, REG_CTR, REG_CFG, REG_STAT, REG_NONE
    } rsu_reg_e;

    typedef struct packed {
        logic valid;    // Packet present in this direction
        logic vring;    // Virtual ring 0 or 1
        logic odd;      // Odd polarity slot
        logic injected; // Packet sent by this stop
    } rsu_dir_s;

    typedef struct packed {
        rsu_dir_s cw;
        rsu_dir_s ccw;
    } rsu_ring_s;

    typedef struct packed {
        rsu_ring_s req;
        rsu_ring_s ack;
        rsu_ring_s data;
        rsu_ring_s inv;
    } rsu_occ_s;

    typedef struct packed {
        logic snoop;
        logic data;
        logic ack;
        logic req;
    } rsu_bounce_s;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } rsu_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsu_axi_rsp_s;

endpackage

/* File: hdl/rsu_evsel.sv */
// Purpose: Per-counter event decode: ring usage and ring bounce hits.
// Assumes: Inputs are same-clock indications, at most one packet per
//          direction per cycle.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/1ps
module rsu_evsel #(
    parameter int CTR_IDX = 0
) (
    // Selection
    input wire logic [7:0] i_event,
    input wire logic [7:0] i_umask,
    input wire logic i_right_side,
    // Ring stop indications
    input wire rsu_pkg::rsu_occ_s i_occ,
    input wire rsu_pkg::rsu_bounce_s i_bounce,
    // Result
    output logic o_hit,
    output logic o_legal
);

    // ==========================================================
    // Elaboration check
    if (CTR_IDX < 0 || CTR_IDX >= rsu_pkg::NUM_CTRS) begin : g_bad_idx
        $error("CTR_IDX out of range");
    end

    // Virtual ring 1 offset in the unit mask
    localparam int UM_V1_BASE_L = rsu_pkg::UM_V1_BASE;

    // ==========================================================
    // Helpers
    // Occupied: passing or sunk, never self-injected
    function automatic logic occupied(input rsu_pkg::rsu_dir_s d);
        return d.valid & ~d.injected;
    endfunction

    // Ring occupancy to unit-mask bit vector
    function automatic logic [7:0] ring_cond(input rsu_pkg::rsu_ring_s r,
                                             input logic right);
        rsu_pkg::rsu_dir_s up;
        rsu_pkg::rsu_dir_s dn;
        logic [7:0] c;
        up = right ? r.ccw : r.cw;
        dn = right ? r.cw : r.ccw;
        c = 8'h00;
        // One packet per direction, so one bit each at most
        if (occupied(up)) begin
            c[{up.vring, 1'b0, up.odd}] = 1'b1;
        end
        if (occupied(dn)) begin
            c[{dn.vring, 1'b1, dn.odd}] = 1'b1;
        end
        return c;
    endfunction

    // Combined two-column count for one direction and parity
    function automatic logic [1:0] comb_sum(input logic [7:0] sel,
                                            input int base);
        return {1'b0, sel[base]} + {1'b0, sel[base+UM_V1_BASE_L]};
    endfunction

    // ==========================================================
    // Decode
    logic [7:0] cond;
    logic [7:0] sel;
    logic [1:0] sum_ue;
    logic [1:0] sum_uo;
    logic [1:0] sum_de;
    logic [1:0] sum_do;
    logic usage;
    logic bounce;
    logic bnc_hit;

    // Pick the ring named by the event code
    always_comb begin
        usage = 1'b1;
        bounce = 1'b0;
        case (i_event)
            rsu_pkg::EV_REQ_USE: cond = ring_cond(i_occ.req, i_right_side);
            rsu_pkg::EV_ACK_USE: cond = ring_cond(i_occ.ack, i_right_side);
            rsu_pkg::EV_DATA_USE: cond = ring_cond(i_occ.data, i_right_side);
            rsu_pkg::EV_INV_USE: cond = ring_cond(i_occ.inv, i_right_side);
            rsu_pkg::EV_BOUNCE: begin
                cond = 8'h00;
                usage = 1'b0;
                bounce = 1'b1;
            end
            default: begin
                cond = 8'h00;
                usage = 1'b0;
            end
        endcase
    end

    // Direction aggregates and per-parity sums
    assign sel = cond & (i_umask & (rsu_pkg::UMASK_UP | rsu_pkg::UMASK_DOWN));
    assign sum_ue = comb_sum(sel, 0);
    assign sum_uo = comb_sum(sel, 1);
    assign sum_de = comb_sum(sel, 2);
    assign sum_do = comb_sum(sel, 3);
    assign bnc_hit = |(i_umask[rsu_pkg::BNC_UMASK_LSB +: 4] & i_bounce);

    // Any selected condition counts once per cycle
    assign o_hit = usage ? |{sum_ue, sum_uo, sum_de, sum_do}
                         : (bounce & bnc_hit);
    assign o_legal = usage ? (CTR_IDX >= rsu_pkg::USAGE_CTR_LO &&
                              CTR_IDX <= rsu_pkg::USAGE_CTR_HI)
                   : bounce ? (CTR_IDX >= rsu_pkg::BOUNCE_CTR_LO &&
                               CTR_IDX <= rsu_pkg::BOUNCE_CTR_HI)
                   : 1'b1;

endmodule

/* File: hdl/rsu_top.sv */
// Purpose: Ring stop usage and bounce event counting for one slice,
//          with four counters behind an AXI4-Lite slave.
// Assumes: Ring indications come from logic on i_clk; single clock.
// Notes:   Write wins over an increment in the same cycle.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module rsu_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register bus
    input wire rsu_pkg::rsu_axi_req_s i_axi,
    output rsu_pkg::rsu_axi_rsp_s o_axi,
    // Ring stop indications
    input wire rsu_pkg::rsu_occ_s i_occ,
    input wire rsu_pkg::rsu_bounce_s i_bounce,
    // Counter activity
    output logic [rsu_pkg::NUM_CTRS-1:0] o_inc
);

    localparam int N = rsu_pkg::NUM_CTRS;

    // ==========================================================
    // State
    typedef struct packed {
        rsu_pkg::rsu_axi_rsp_s rsp;
        logic aw_full;
        logic [rsu_pkg::ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [N-1:0][31:0] ctl;
        logic [N-1:0][31:0] ctr;
        logic [31:0] cfg;
        logic [N-1:0] bad_sel;
        logic right_side;
        logic [N-1:0] inc;
    } rsu_state_s;

    rsu_state_s st_q;
    rsu_state_s st_d;

    // ==========================================================
    // Helpers
    // Address to register kind
    function automatic rsu_pkg::rsu_reg_e decode(
            input logic [rsu_pkg::ADDR_W-1:0] a);
        if (a[1:0] != 2'h0) begin
            return rsu_pkg::REG_NONE;
        end else if (a[7:4] == rsu_pkg::ADDR_CTL0[7:4]) begin
            return rsu_pkg::REG_CTL;
        end else if (a[7:4] == rsu_pkg::ADDR_CTR0[7:4]) begin
            return rsu_pkg::REG_CTR;
        end else if (a == rsu_pkg::ADDR_CFG) begin
            return rsu_pkg::REG_CFG;
        end else if (a == rsu_pkg::ADDR_STAT) begin
            return rsu_pkg::REG_STAT;
        end
        return rsu_pkg::REG_NONE;
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Side of the ring from slice position
    function automatic logic side_right(input logic [31:0] cfg);
        logic [rsu_pkg::SLICE_W-1:0] id;
        logic [rsu_pkg::SLICE_W-1:0] cnt;
        id = cfg[rsu_pkg::CFG_ID_LSB +: rsu_pkg::SLICE_W];
        cnt = cfg[rsu_pkg::CFG_COUNT_LSB +: rsu_pkg::SLICE_W];
        return id >= (cnt >> 1);
    endfunction

    // ==========================================================
    // Event decode per counter
    logic [N-1:0] hit;
    logic [N-1:0] legal;
    logic [N-1:0] en;
    logic [N-1:0] ctr_wr;
    logic wr_exec;
    rsu_pkg::rsu_reg_e wr_kind;
    rsu_pkg::rsu_reg_e rd_kind;

    for (genvar g = 0; g < N; g++) begin : g_sel
        rsu_evsel #(
            .CTR_IDX(g)
        ) u_evsel (
            .i_event(st_q.ctl[g][rsu_pkg::CTL_EVENT_LSB +: 8]),
            .i_umask(st_q.ctl[g][rsu_pkg::CTL_UMASK_LSB +: 8]),
            .i_right_side(st_q.right_side),
            .i_occ(i_occ),
            .i_bounce(i_bounce),
            .o_hit(hit[g]),
            .o_legal(legal[g])
        );
        assign en[g] = st_q.ctl[g][rsu_pkg::CTL_ENABLE_BIT];
        assign ctr_wr[g] = wr_exec && wr_kind == rsu_pkg::REG_CTR &&
                           st_q.aw_addr[3:2] == 2'(g);
    end

    // Write fires once address and data are both held and no write response is pending
    assign wr_exec = st_q.aw_full && st_q.w_full && !st_q.rsp.bvalid;
    assign wr_kind = decode(st_q.aw_addr);
    assign rd_kind = decode(i_axi.araddr);

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        // Channel captures
        if (i_axi.awvalid && st_q.rsp.awready) begin
            st_d.aw_full = 1'b1;
            st_d.aw_addr = i_axi.awaddr;
        end
        if (i_axi.wvalid && st_q.rsp.wready) begin
            st_d.w_full = 1'b1;
            st_d.w_data = i_axi.wdata;
            st_d.w_strb = i_axi.wstrb;
        end
        if (st_q.rsp.bvalid && i_axi.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        // Counting, at most one per cycle each
        for (int i = 0; i < N; i++) begin
            st_d.inc[i] = hit[i] & legal[i] & en[i];
            st_d.bad_sel[i] = ~legal[i];
            if (st_d.inc[i]) begin
                st_d.ctr[i] = st_q.ctr[i] + 32'h1;
            end
        end
        // Register write, overriding a same-cycle increment
        if (wr_exec) begin
            st_d.aw_full = 1'b0;
            st_d.w_full = 1'b0;
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp = rsu_pkg::RESP_OKAY;
            case (wr_kind)
                rsu_pkg::REG_CTL: begin
                    st_d.ctl[st_q.aw_addr[3:2]] = merge(
                        st_q.ctl[st_q.aw_addr[3:2]], st_q.w_data,
                        st_q.w_strb);
                end
                rsu_pkg::REG_CTR: begin
                    st_d.ctr[st_q.aw_addr[3:2]] = merge(
                        st_q.ctr[st_q.aw_addr[3:2]], st_q.w_data,
                        st_q.w_strb);
                end
                rsu_pkg::REG_CFG: begin
                    st_d.cfg = merge(st_q.cfg, st_q.w_data, st_q.w_strb);
                end
                rsu_pkg::REG_STAT: begin
                    st_d.rsp.bresp = rsu_pkg::RESP_OKAY;
                end
                default: begin
                    st_d.rsp.bresp = rsu_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Read channel
        if (st_q.rsp.rvalid && i_axi.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (i_axi.arvalid && st_q.rsp.arready) begin
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rresp = rsu_pkg::RESP_OKAY;
            st_d.rsp.rdata = 32'h0;
            case (rd_kind)
                rsu_pkg::REG_CTL: st_d.rsp.rdata = st_q.ctl[i_axi.araddr[3:2]];
                rsu_pkg::REG_CTR: st_d.rsp.rdata = st_q.ctr[i_axi.araddr[3:2]];
                rsu_pkg::REG_CFG: st_d.rsp.rdata = st_q.cfg;
                rsu_pkg::REG_STAT: begin
                    st_d.rsp.rdata[N-1:0] = st_q.bad_sel;
                    st_d.rsp.rdata[rsu_pkg::STAT_SIDE_BIT] = st_q.right_side;
                end
                default: st_d.rsp.rresp = rsu_pkg::RESP_SLVERR;
            endcase
        end
        // Side follows configuration
        st_d.right_side = side_right(st_q.cfg);
        // Ready flags from the held state
        st_d.rsp.awready = ~st_d.aw_full;
        st_d.rsp.wready = ~st_d.w_full;
        st_d.rsp.arready = ~st_d.rsp.rvalid;
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
            st_q.rsp.awready <= 1'b1;
            st_q.rsp.wready <= 1'b1;
            st_q.rsp.arready <= 1'b1;
            st_q.ctl <= {N{rsu_pkg::CTL_RST}};
            st_q.ctr <= {N{rsu_pkg::CTR_RST}};
            st_q.cfg <= rsu_pkg::CFG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from state
    assign o_axi = st_q.rsp;
    assign o_inc = st_q.inc;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    logic [7:0] ev0;
    logic [7:0] ev1;
    logic [7:0] ev2;
    logic [7:0] ev3;
    assign ev0 = st_q.ctl[0][rsu_pkg::CTL_EVENT_LSB +: 8];
    assign ev1 = st_q.ctl[1][rsu_pkg::CTL_EVENT_LSB +: 8];
    assign ev2 = st_q.ctl[2][rsu_pkg::CTL_EVENT_LSB +: 8];
    assign ev3 = st_q.ctl[3][rsu_pkg::CTL_EVENT_LSB +: 8];

    for (genvar a = 0; a < N; a++) begin : g_ast
        AST_STEP_ONE: assert property (
            !ctr_wr[a] |=> (st_q.ctr[a] - $past(st_q.ctr[a])) <= 32'h1)
            else $error("counter stepped by more than one");
    end

    AST_LOW_NO_USAGE: assert property (
        (ev0 == rsu_pkg::EV_REQ_USE || ev0 == rsu_pkg::EV_INV_USE) &&
        !ctr_wr[0] |=> $stable(st_q.ctr[0]))
        else $error("usage event counted on counter 0");

    AST_HIGH_NO_BOUNCE: assert property (
        ev2 == rsu_pkg::EV_BOUNCE && !ctr_wr[2] |=> $stable(st_q.ctr[2]))
        else $error("bounce event counted on counter 2");

    AST_REQ_COUNT: assert property (
        ev2 == rsu_pkg::EV_REQ_USE && en[2] && !ctr_wr[2] &&
        st_q.ctl[2][rsu_pkg::CTL_UMASK_LSB +: 8] == 8'hff &&
        i_occ.req.cw.valid && !i_occ.req.cw.injected
        |=> st_q.ctr[2] == $past(st_q.ctr[2]) + 32'h1 && st_q.inc[2])
        else $error("request ring occupancy not counted");

    AST_INJECT_EXCL: assert property (
        ev3 == rsu_pkg::EV_DATA_USE && !ctr_wr[3] &&
        (!i_occ.data.cw.valid || i_occ.data.cw.injected) &&
        (!i_occ.data.ccw.valid || i_occ.data.ccw.injected)
        |=> $stable(st_q.ctr[3]))
        else $error("injected packet counted");

    AST_UMASK_ZERO: assert property (
        ev3 == rsu_pkg::EV_ACK_USE && !ctr_wr[3] &&
        st_q.ctl[3][rsu_pkg::CTL_UMASK_LSB +: 8] == 8'h00
        |=> !st_q.inc[3])
        else $error("count with empty unit mask");

    AST_SIDE: assert property (
        $stable(st_q.cfg) |-> st_q.right_side == side_right(st_q.cfg))
        else $error("ring side does not follow slice position");

    AST_BRESP: assert property (
        wr_exec |=> st_q.rsp.bvalid && !st_q.aw_full && !st_q.w_full)
        else $error("write response missing");

    AST_RHOLD: assert property (
        st_q.rsp.rvalid && !i_axi.rready |=>
        st_q.rsp.rvalid && $stable(st_q.rsp.rdata))
        else $error("read data dropped before taken");

    // Bounce hits land on counter 0
    AST_BNC_COUNT: assert property (
        ev0 == rsu_pkg::EV_BOUNCE && en[0] && !ctr_wr[0] &&
        (st_q.ctl[0][rsu_pkg::CTL_UMASK_LSB+rsu_pkg::BNC_UMASK_LSB +: 4] &
        i_bounce) != 4'h0 |=> st_q.inc[0])
        else $error("bounce not counted on counter 0");

    // Usage codes never count on counter 1
    AST_CTR1_NO_USAGE: assert property (
        ev1 >= rsu_pkg::EV_REQ_USE && ev1 <= rsu_pkg::EV_INV_USE
        |=> !st_q.inc[1])
        else $error("usage event counted on counter 1");

    // Right side: clockwise traffic is down
    AST_RIGHT_SWAP: assert property (
        st_q.right_side && ev2 == rsu_pkg::EV_REQ_USE &&
        (st_q.ctl[2][rsu_pkg::CTL_UMASK_LSB +: 8] & rsu_pkg::UMASK_DOWN) ==
        8'h00 && !i_occ.req.ccw.valid |=> !st_q.inc[2])
        else $error("clockwise traffic counted as up on right side");

    // Counter write wins over an increment
    AST_WR_WINS: assert property (
        ctr_wr[2] && st_q.w_strb == 4'hf |=>
        st_q.ctr[2] == $past(st_q.w_data))
        else $error("counter write lost to an increment");

    // Unmapped write refused
    AST_WR_ERR: assert property (
        wr_exec && wr_kind == rsu_pkg::REG_NONE |=>
        st_q.rsp.bresp == rsu_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");

    // Unmapped read refused with zero data
    AST_RD_ERR: assert property (
        i_axi.arvalid && st_q.rsp.arready && rd_kind == rsu_pkg::REG_NONE
        |=> st_q.rsp.rresp == rsu_pkg::RESP_SLVERR &&
        st_q.rsp.rdata == 32'h0)
        else $error("unmapped read not refused");

    // Main scenarios reached
    COV_WR_HIT: cover property (ctr_wr[2] && hit[2] && en[2]);
    COV_REQ: cover property (st_q.inc[2] && ev2 == rsu_pkg::EV_REQ_USE);
    COV_BOUNCE: cover property (st_q.inc[0] && ev0 == rsu_pkg::EV_BOUNCE);
    COV_RIGHT: cover property (st_q.right_side ##1 st_q.inc[3]);
    COV_ERR: cover property (st_q.rsp.bvalid &&
                             st_q.rsp.bresp == rsu_pkg::RESP_SLVERR);

endmodule

/* File: tb/rsu_ring_model.sv */
// Purpose: Ring stop traffic source for occupancy and bounce lines.
// Assumes: Commands change just after a rising edge.
// Notes:   Empty slots carry a toggling pattern in their qualifiers.
`timescale 1ns/1ps
module rsu_ring_model (
    // Clock
    input wire logic i_clk,
    // Command
    input wire logic i_go,
    input wire logic [1:0] i_ring,
    input wire logic [1:0] i_dirs,
    input wire logic [2:0] i_qual,
    input wire logic [3:0] i_bnc,
    // Stop indications
    output rsu_pkg::rsu_occ_s o_occ,
    output rsu_pkg::rsu_bounce_s o_bounce
);
    // ==========================================================
    // Slot generation
    logic tgl = 1'b0;
    logic sel;
    rsu_pkg::rsu_dir_s idle;
    rsu_pkg::rsu_dir_s pkt;
    rsu_pkg::rsu_ring_s rg [4];

    // One slot per direction, so one packet up and one down at most
    always @(posedge i_clk) begin
        idle = {1'b0, tgl, ~tgl, tgl};
        pkt = {1'b1, i_qual}; // Own injections flagged
        for (int r = 0; r < 4; r++) begin
            sel = i_go && (i_ring == 2'(r));
            rg[r].cw = (sel && i_dirs[1]) ? pkt : idle;
            rg[r].ccw = (sel && i_dirs[0]) ? pkt : idle;
        end
        tgl <= ~tgl;
        o_occ <= {rg[0], rg[1], rg[2], rg[3]};
        o_bounce <= i_go ? i_bnc : 4'h0;
    end
endmodule

/* File: tb/test_ring_stop_usage_event_select.sv */
// Purpose: Self-checking bench for the ring stop usage event block.
// Assumes: Slice count 2, so slice id 1 sits on the right side.
// Notes:   Rows give selection, traffic and the expected increment.
`timescale 1ns/1ps
module test_ring_stop_usage_event_select;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [7:0] ev;
        logic [7:0] um;
        logic [1:0] ring;
        logic [1:0] dirs;
        logic [2:0] q;
        logic [3:0] bnc;
        logic [1:0] ctr;
        logic right;
        logic exp;
    } rsu_row_s;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    rsu_pkg::rsu_axi_req_s axi = '0;
    rsu_pkg::rsu_axi_rsp_s rsp;
    rsu_pkg::rsu_occ_s occ;
    rsu_pkg::rsu_bounce_s bnc;
    logic [3:0] inc;
    rsu_row_s cmd = '0;
    logic go = 1'b0;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    rsu_row_s both = '{8'h1b,8'hff,2'h0,2'h3,3'h0,4'h0,2'h2,1'h0,1'h1};
    rsu_row_s rows [24] = '{
        '{8'h1b,8'h01,2'h0,2'h2,3'h0,4'h0,2'h2,1'h0,1'h1},
        '{8'h1c,8'h02,2'h1,2'h2,3'h2,4'h0,2'h3,1'h0,1'h1},
        '{8'h1d,8'h04,2'h2,2'h1,3'h0,4'h0,2'h2,1'h0,1'h1},
        '{8'h1e,8'h08,2'h3,2'h1,3'h2,4'h0,2'h3,1'h0,1'h1},
        '{8'h1b,8'h10,2'h0,2'h2,3'h4,4'h0,2'h2,1'h0,1'h1},
        '{8'h1b,8'h40,2'h0,2'h1,3'h4,4'h0,2'h3,1'h0,1'h1},
        '{8'h1b,8'h80,2'h0,2'h1,3'h6,4'h0,2'h2,1'h0,1'h1},
        '{8'h1b,8'h01,2'h0,2'h2,3'h0,4'h0,2'h2,1'h1,1'h0},
        '{8'h1b,8'h04,2'h0,2'h2,3'h0,4'h0,2'h3,1'h1,1'h1},
        '{8'h1b,8'hff,2'h0,2'h2,3'h1,4'h0,2'h2,1'h0,1'h0},
        '{8'h1b,8'hff,2'h0,2'h2,3'h0,4'h0,2'h0,1'h0,1'h0},
        '{8'h1d,8'hff,2'h2,2'h1,3'h0,4'h0,2'h1,1'h0,1'h0},
        '{8'h1b,8'h33,2'h0,2'h2,3'h6,4'h0,2'h2,1'h0,1'h1},
        '{8'h1b,8'hcc,2'h0,2'h2,3'h6,4'h0,2'h3,1'h0,1'h0},
        '{8'h1b,8'h33,2'h0,2'h1,3'h2,4'h0,2'h2,1'h1,1'h1},
        '{8'h1c,8'hff,2'h2,2'h2,3'h0,4'h0,2'h2,1'h0,1'h0},
        '{8'h1c,8'h00,2'h1,2'h3,3'h0,4'h0,2'h3,1'h0,1'h0},
        '{8'h1d,8'hff,2'h2,2'h3,3'h1,4'h0,2'h3,1'h0,1'h0},
        '{8'h05,8'h02,2'h0,2'h0,3'h0,4'h1,2'h0,1'h0,1'h1},
        '{8'h05,8'h04,2'h0,2'h0,3'h0,4'h2,2'h1,1'h0,1'h1},
        '{8'h05,8'h08,2'h0,2'h0,3'h0,4'h4,2'h0,1'h0,1'h1},
        '{8'h05,8'h10,2'h0,2'h0,3'h0,4'h8,2'h1,1'h0,1'h1},
        '{8'h05,8'h02,2'h0,2'h0,3'h0,4'h2,2'h0,1'h0,1'h0},
        '{8'h05,8'hff,2'h0,2'h0,3'h0,4'h1,2'h2,1'h0,1'h0}
    };

    // ==========================================================
    // Instances
    rsu_top u_rsu_top (.i_clk(i_clk), .i_rst(i_rst), .i_axi(axi),
        .o_axi(rsp), .i_occ(occ), .i_bounce(bnc), .o_inc(inc));
    rsu_ring_model u_rsu_ring_model (.i_clk(i_clk), .i_go(go),
        .i_ring(cmd.ring), .i_dirs(cmd.dirs), .i_qual(cmd.q),
        .i_bnc(cmd.bnc), .o_occ(occ), .o_bounce(bnc));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] ctl_a(input logic [1:0] n);
        return rsu_pkg::ADDR_CTL0 + {4'h0, n, 2'h0};
    endfunction

    function automatic logic [31:0] ctl_v(input logic [7:0] ev, um);
        return {9'h0, 1'b1, 6'h0, um, ev};
    endfunction

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
        bit done;
        done = 0;
        @(posedge i_clk);
        axi.awaddr <= a;
        axi.wdata <= d;
        axi.wstrb <= 4'hf;
        axi.awvalid <= 1'b1;
        axi.wvalid <= 1'b1;
        axi.bready <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
            if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                resp = rsp.bresp;
                axi.bready <= 1'b0;
                done = 1;
            end
        end
        check("wr_taken", {30'h0, axi.awvalid, axi.wvalid}, 32'h0);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        bit done;
        done = 0;
        @(posedge i_clk);
        axi.araddr <= a;
        axi.arvalid <= 1'b1;
        axi.rready <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                d = rsp.rdata;
                resp = rsp.rresp;
                axi.rready <= 1'b0;
                done = 1;
            end
        end
        check("rd_taken", {31'h0, axi.arvalid}, 32'h0);
    endtask

    // Traffic for n cycles; returns once the last increment has landed
    task automatic pulse(input rsu_row_s r, input int n);
        @(posedge i_clk);
        cmd <= r;
        go <= 1'b1;
        repeat (n) @(posedge i_clk);
        go <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    initial begin
        #(25 * 8000);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            axi_wr(rsu_pkg::ADDR_CFG, rows[i].right ? 32'h0000_0201 :
                   rsu_pkg::CFG_RST, rs);
            axi_wr(ctl_a(rows[i].ctr), ctl_v(rows[i].ev, rows[i].um), rs);
            pulse(rows[i], 1);
            check("inc", {31'h0, inc[rows[i].ctr]}, {31'h0, rows[i].exp});
        end
        // Placement flags: bounce left on counter 2
        axi_rd(rsu_pkg::ADDR_STAT, rd, rs);
        check("stat", rd, 32'h4);
        // Both directions busy, three cycles back to back
        axi_wr(ctl_a(2'h2), ctl_v(rsu_pkg::EV_REQ_USE, 8'hff), rs);
        axi_wr(rsu_pkg::ADDR_CTR0 + 8'h08, 32'h0, rs);
        pulse(both, 3);
        axi_rd(rsu_pkg::ADDR_CTR0 + 8'h08, rd, rs);
        check("ctr2", rd, 32'h3);
        // Bus errors and a read-only place
        axi_rd(8'h30, rd, rs);
        check("bad_resp", {30'h0, rs}, {30'h0, rsu_pkg::RESP_SLVERR});
        axi_wr(8'h30, 32'h0, rs);
        check("bad_wr", {30'h0, rs}, {30'h0, rsu_pkg::RESP_SLVERR});
        axi_wr(rsu_pkg::ADDR_STAT, 32'hffff_ffff, rs);
        check("stat_resp", {30'h0, rs}, {30'h0, rsu_pkg::RESP_OKAY});
        axi_wr(rsu_pkg::ADDR_CFG, 32'h0000_0201, rs);
        // Reset in mid-run with traffic still flowing
        @(posedge i_clk);
        cmd <= both;
        go <= 1'b1;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        check("inc_rst", {28'h0, inc}, 32'h0);
        @(posedge i_clk);
        go <= 1'b0;
        i_rst <= 1'b0;
        axi_rd(rsu_pkg::ADDR_CFG, rd, rs);
        check("cfg_rst", rd, rsu_pkg::CFG_RST);
        axi_rd(ctl_a(2'h2), rd, rs);
        check("ctl_rst", rd, rsu_pkg::CTL_RST);
        axi_rd(rsu_pkg::ADDR_CTR0 + 8'h08, rd, rs);
        check("ctr_rst", rd, rsu_pkg::CTR_RST);
        end_of_test();
    end
endmodule
